// ### logic/rpsm_defines.svh
// Register offsets, field positions, reset values and timing figures of the port status monitor.
`ifndef RPSM_DEFINES_SVH
`define RPSM_DEFINES_SVH

`define RPSM_ADDR_PORT_SEL 8'h4C
`define RPSM_ADDR_STATUS 8'h4E
`define RPSM_ADDR_FREQ_INT 8'h4F
`define RPSM_ADDR_FREQ_FRAC 8'h50

`define RPSM_BIT_LEN_UNSTABLE 7
`define RPSM_BIT_LEN_CHANGED 6
`define RPSM_BIT_CODING_ERR 5
`define RPSM_BIT_BUF_ERR 4
`define RPSM_BIT_CSI_ERR 3
`define RPSM_BIT_FREQ_SETTLED 2
`define RPSM_BIT_CLK_ABSENT 1
`define RPSM_BIT_CNT_CHANGED 0

`define RPSM_CLEAR_ON_READ_MASK 8'hF1
`define RPSM_RESET_BYTE 8'h00
`define RPSM_FREQ_RESET 16'h0000
`define RPSM_UNMAPPED_DATA 8'h00

`define RPSM_CLK_PERIOD_NS 10
`define RPSM_GATE_TIME_NS 256000
`define RPSM_FREQ_TOL 16'h0010
`define RPSM_SAT16 16'hFFFF

`endif

// ### logic/rpsm_pkg.sv
// Types shared by the port status monitor modules.
package rpsm_pkg;

    typedef struct packed {
        logic frame_start;
        logic line_end;
        logic coding_err;
        logic buf_overflow;
        logic csi_error;
    } rpsm_port_in_type;

    typedef struct packed {
        logic len_unstable;
        logic len_changed;
        logic cnt_changed;
    } rpsm_line_ev_type;

    typedef struct packed {
        logic [7:0] integer_mhz;
        logic [7:0] fraction_mhz;
    } rpsm_freq_type;

endpackage

// ### logic/rpsm_line_mon.sv
// Line length and line count watcher for one receive port.
`timescale 1ns/1ps
`include "rpsm_defines.svh"
module rpsm_line_mon
    import rpsm_pkg::*;
#(
    parameter int LW = 16
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic frame_start_i,
    input wire logic line_end_i,
    output rpsm_line_ev_type ev_o
);
    logic [LW-1:0] len_q, len_d, prev_q, prev_d, ref_len_q, ref_len_d;
    logic [LW-1:0] cnt_q, cnt_d, ref_cnt_q, ref_cnt_d;
    logic seen_q, seen_d, ref_ok_q, ref_ok_d, unst_q, unst_d;
    rpsm_line_ev_type ev_q, ev_d;

    always_comb begin
        len_d = (&len_q) ? len_q : len_q + LW'(1);
        prev_d = prev_q;
        cnt_d = cnt_q;
        seen_d = seen_q;
        unst_d = unst_q;
        ref_len_d = ref_len_q;
        ref_cnt_d = ref_cnt_q;
        ref_ok_d = ref_ok_q;
        ev_d = '0;
        if (frame_start_i) begin
            // The closing frame is judged only if it held at least one line.
            ev_d.len_unstable = seen_q && unst_q;
            ev_d.len_changed = seen_q && ref_ok_q && (prev_q != ref_len_q);
            ev_d.cnt_changed = seen_q && ref_ok_q && (cnt_q != ref_cnt_q);
            if (seen_q) begin
                ref_len_d = prev_q;
                ref_cnt_d = cnt_q;
                ref_ok_d = 1'b1;
            end
            len_d = '0;
            cnt_d = '0;
            seen_d = 1'b0;
            unst_d = 1'b0;
        end else if (line_end_i) begin
            if (seen_q && (len_q != prev_q)) begin
                unst_d = 1'b1;
            end
            prev_d = len_q;
            cnt_d = (&cnt_q) ? cnt_q : cnt_q + LW'(1);
            seen_d = 1'b1;
            len_d = '0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            len_q <= '0;
            prev_q <= '0;
            cnt_q <= '0;
            seen_q <= 1'b0;
            unst_q <= 1'b0;
            ref_len_q <= '0;
            ref_cnt_q <= '0;
            ref_ok_q <= 1'b0;
            ev_q <= '0;
        end else begin
            len_q <= len_d;
            prev_q <= prev_d;
            cnt_q <= cnt_d;
            seen_q <= seen_d;
            unst_q <= unst_d;
            ref_len_q <= ref_len_d;
            ref_cnt_q <= ref_cnt_d;
            ref_ok_q <= ref_ok_d;
            ev_q <= ev_d;
        end
    end

    assign ev_o = ev_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    a_unstable_reported: assert property (
        (line_end_i && !frame_start_i && seen_q && len_q != prev_q)
        ##1 (!frame_start_i) [*1] ##1 frame_start_i |=> ev_q.len_unstable)
        else $error("Unequal line lengths not reported at frame start.");
endmodule // rpsm_line_mon

// ### logic/rpsm_freq_meter.sv
// Gated edge counter measuring one port's link clock in 1/256 MHz steps.
`timescale 1ns/1ps
`include "rpsm_defines.svh"
module rpsm_freq_meter
    import rpsm_pkg::*;
#(
    parameter int GATE_CYCLES = `RPSM_GATE_TIME_NS / `RPSM_CLK_PERIOD_NS,
    parameter logic [15:0] TOL = `RPSM_FREQ_TOL
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic link_clk_i,
    input wire logic [7:0] low_thresh_i,
    output rpsm_freq_type freq_o,
    output logic settled_o,
    output logic absent_o
);
    localparam int GW = $clog2(GATE_CYCLES + 1);
    logic s1_q, s2_q, s3_q;
    logic [GW-1:0] gate_q, gate_d;
    logic [15:0] edges_q, edges_d, edges_nx, diff;
    rpsm_freq_type freq_q, freq_d;
    logic valid_q, valid_d, settled_q, settled_d, absent_q, absent_d, gate_end;

    // With a 256 us gate the edge count is already MHz in 8.8 fixed point.
    always_comb begin
        gate_end = (gate_q == GW'(GATE_CYCLES - 1));
        edges_nx = edges_q;
        if (s2_q && !s3_q && edges_q != `RPSM_SAT16) begin
            edges_nx = edges_q + 16'h0001;
        end
        diff = (edges_nx > freq_q) ? edges_nx - freq_q : freq_q - edges_nx;
        gate_d = gate_end ? '0 : gate_q + GW'(1);
        edges_d = gate_end ? 16'h0000 : edges_nx;
        freq_d = freq_q;
        valid_d = valid_q;
        settled_d = settled_q;
        absent_d = absent_q;
        if (gate_end) begin
            freq_d = edges_nx;
            valid_d = 1'b1;
            absent_d = (edges_nx[15:8] < low_thresh_i);
            settled_d = valid_q && (diff <= TOL) && (edges_nx[15:8] >= low_thresh_i);
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            gate_q <= '0;
            edges_q <= `RPSM_FREQ_RESET;
            freq_q <= `RPSM_FREQ_RESET;
            valid_q <= 1'b0;
            settled_q <= 1'b0;
            absent_q <= 1'b0;
        end else begin
            s1_q <= link_clk_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            gate_q <= gate_d;
            edges_q <= edges_d;
            freq_q <= freq_d;
            valid_q <= valid_d;
            settled_q <= settled_d;
            absent_q <= absent_d;
        end
    end

    assign freq_o = freq_q;
    assign settled_o = settled_q;
    assign absent_o = absent_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    a_freq_both_bytes: assert property (gate_end |=> freq_q == $past(edges_nx))
        else $error("Frequency bytes not loaded together at gate end.");
    a_freq_held: assert property (!gate_end |=> $stable(freq_q))
        else $error("Frequency changed between gate ends.");
    a_absent_below: assert property (gate_end && edges_nx[15:8] < low_thresh_i |=> absent_q)
        else $error("Clock absence not flagged below threshold.");
    a_settled_excl: assert property (settled_q |-> !absent_q)
        else $error("Settled while clock absent.");
endmodule // rpsm_freq_meter

// ### logic/rpsm_top.sv
// Per-port receive status flags and link frequency registers with port-selected access.
`timescale 1ns/1ps
`include "rpsm_defines.svh"
module rpsm_top
    import rpsm_pkg::*;
#(
    parameter int NUM_PORTS = 4,
    parameter int GATE_CYCLES = `RPSM_GATE_TIME_NS / `RPSM_CLK_PERIOD_NS,
    parameter logic [15:0] FREQ_TOL = `RPSM_FREQ_TOL,
    parameter int LW = 16
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input rpsm_port_in_type port_in_i [NUM_PORTS],
    input wire logic [NUM_PORTS-1:0] link_clk_i,
    input wire logic [NUM_PORTS-1:0][7:0] low_freq_thresh_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o
);
    localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    rpsm_line_ev_type line_ev [NUM_PORTS];
    rpsm_freq_type freq [NUM_PORTS];
    logic [NUM_PORTS-1:0] settled, absent;
    logic [7:0] set_bits [NUM_PORTS];

    // Each receive port has its own monitors; only the register view is shared.
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        rpsm_line_mon #(
            .LW(LW)
        ) u_line (
            .core_clk_i(core_clk_i),
            .nrst_i(nrst_i),
            .frame_start_i(port_in_i[p].frame_start),
            .line_end_i(port_in_i[p].line_end),
            .ev_o(line_ev[p])
        );

        rpsm_freq_meter #(
            .GATE_CYCLES(GATE_CYCLES),
            .TOL(FREQ_TOL)
        ) u_freq (
            .core_clk_i(core_clk_i),
            .nrst_i(nrst_i),
            .link_clk_i(link_clk_i[p]),
            .low_thresh_i(low_freq_thresh_i[p]),
            .freq_o(freq[p]),
            .settled_o(settled[p]),
            .absent_o(absent[p])
        );

        always_comb begin
            set_bits[p] = `RPSM_RESET_BYTE;
            set_bits[p][`RPSM_BIT_LEN_UNSTABLE] = line_ev[p].len_unstable;
            set_bits[p][`RPSM_BIT_LEN_CHANGED] = line_ev[p].len_changed;
            // Coding errors only arrive while the receiver stays locked.
            set_bits[p][`RPSM_BIT_CODING_ERR] = port_in_i[p].coding_err;
            set_bits[p][`RPSM_BIT_BUF_ERR] = port_in_i[p].buf_overflow;
            set_bits[p][`RPSM_BIT_CNT_CHANGED] = line_ev[p].cnt_changed;
        end
    end

    logic [PW-1:0] sel_q, sel_d;
    logic [7:0] flags_q [NUM_PORTS];
    logic [7:0] flags_d [NUM_PORTS];
    logic [7:0] frac_shadow_q, frac_shadow_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic rd_status, rd_int;
    logic [7:0] status_view;

    always_comb begin
        rd_status = reg_rd_i && hit(reg_addr_i, `RPSM_ADDR_STATUS);
        rd_int = reg_rd_i && hit(reg_addr_i, `RPSM_ADDR_FREQ_INT);
        sel_d = sel_q;
        if (reg_wr_i && hit(reg_addr_i, `RPSM_ADDR_PORT_SEL)) begin
            sel_d = reg_wdata_i[PW-1:0];
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            flags_d[p] = flags_q[p];
            // A set arriving in the clearing cycle survives the read.
            if (rd_status && sel_q == PW'(p)) begin
                flags_d[p] = flags_d[p] & ~`RPSM_CLEAR_ON_READ_MASK;
            end
            flags_d[p] = flags_d[p] | set_bits[p];
        end
    end

    always_comb begin
        status_view = flags_q[sel_q] & `RPSM_CLEAR_ON_READ_MASK;
        status_view[`RPSM_BIT_CSI_ERR] = port_in_i[sel_q].csi_error;
        status_view[`RPSM_BIT_FREQ_SETTLED] = settled[sel_q];
        status_view[`RPSM_BIT_CLK_ABSENT] = absent[sel_q];
    end

    always_comb begin
        rvalid_d = reg_rd_i;
        rdata_d = `RPSM_UNMAPPED_DATA;
        frac_shadow_d = frac_shadow_q;
        // Reading the integer byte freezes the matching fraction for the next read.
        if (rd_int) begin
            frac_shadow_d = freq[sel_q].fraction_mhz;
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `RPSM_ADDR_PORT_SEL: begin
                    rdata_d[PW-1:0] = sel_q;
                end
                `RPSM_ADDR_STATUS: begin
                    rdata_d = status_view;
                end
                `RPSM_ADDR_FREQ_INT: begin
                    rdata_d = freq[sel_q].integer_mhz;
                end
                `RPSM_ADDR_FREQ_FRAC: begin
                    rdata_d = frac_shadow_q;
                end
                default: begin
                    rdata_d = `RPSM_UNMAPPED_DATA;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_q <= '0;
            for (int p = 0; p < NUM_PORTS; p++) begin
                flags_q[p] <= `RPSM_RESET_BYTE;
            end
            frac_shadow_q <= `RPSM_RESET_BYTE;
            rdata_q <= `RPSM_RESET_BYTE;
            rvalid_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            for (int p = 0; p < NUM_PORTS; p++) begin
                flags_q[p] <= flags_d[p];
            end
            frac_shadow_q <= frac_shadow_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    a_unstable_sticky: assert property (
        flags_q[0][`RPSM_BIT_LEN_UNSTABLE] && !(rd_status && sel_q == '0)
        |=> flags_q[0][`RPSM_BIT_LEN_UNSTABLE])
        else $error("Instability flag dropped without a read.");
    a_lenchg_clear: assert property (
        rd_status && sel_q == '0 && !set_bits[0][`RPSM_BIT_LEN_CHANGED]
        |=> !flags_q[0][`RPSM_BIT_LEN_CHANGED])
        else $error("Line length flag not cleared by read.");
    a_coding_set_wins: assert property (
        port_in_i[0].coding_err |=> flags_q[0][`RPSM_BIT_CODING_ERR] ##1 1'b1)
        else $error("Coding error lost.");
    a_buffer_clear: assert property (
        rd_status && sel_q == '0 && !port_in_i[0].buf_overflow
        |=> !flags_q[0][`RPSM_BIT_BUF_ERR])
        else $error("Buffer flag not cleared by read.");
    a_cntchg_read: assert property (
        rd_status && flags_q[sel_q][`RPSM_BIT_CNT_CHANGED]
        |=> reg_rvalid_o && reg_rdata_o[`RPSM_BIT_CNT_CHANGED])
        else $error("Line count flag not returned on read.");
    a_csi_live: assert property (
        rd_status |=> reg_rdata_o[`RPSM_BIT_CSI_ERR] == $past(port_in_i[sel_q].csi_error))
        else $error("Camera error summary not live.");
    a_absent_shown: assert property (
        rd_status |=> reg_rdata_o[`RPSM_BIT_CLK_ABSENT] == $past(absent[sel_q]))
        else $error("Clock absence bit wrong.");
    a_int_byte: assert property (
        rd_int |=> reg_rdata_o == $past(freq[sel_q].integer_mhz))
        else $error("Integer frequency byte wrong.");
    a_frac_pair: assert property (
        rd_int ##1 !rd_int ##1 (reg_rd_i && hit(reg_addr_i, `RPSM_ADDR_FREQ_FRAC))
        |=> reg_rdata_o == $past(freq[sel_q].fraction_mhz, 3))
        else $error("Fraction byte not paired with integer byte.");
    a_select_read: assert property (
        reg_wr_i && hit(reg_addr_i, `RPSM_ADDR_PORT_SEL) ##1 !reg_wr_i ##1
        (reg_rd_i && hit(reg_addr_i, `RPSM_ADDR_PORT_SEL))
        |=> reg_rdata_o[PW-1:0] == $past(reg_wdata_i[PW-1:0], 3))
        else $error("Port select not read back.");

    // The answer is framed by one cycle of valid and idles at zero around it.
    a_rvalid_pulse: assert property (
        reg_rvalid_o == $past(reg_rd_i))
        else $error("Read answer not exactly one cycle after the read.");
    a_idle_zero: assert property (
        !reg_rd_i |=> reg_rdata_o == `RPSM_UNMAPPED_DATA)
        else $error("Read data not idle after a quiet cycle.");
    a_unmapped_zero: assert property (
        reg_rd_i && !hit(reg_addr_i, `RPSM_ADDR_PORT_SEL) && !hit(reg_addr_i, `RPSM_ADDR_STATUS)
        && !hit(reg_addr_i, `RPSM_ADDR_FREQ_INT) && !hit(reg_addr_i, `RPSM_ADDR_FREQ_FRAC)
        |=> reg_rdata_o == `RPSM_UNMAPPED_DATA)
        else $error("Unmapped address returned data.");
    a_sel_upper_zero: assert property (
        reg_rd_i && hit(reg_addr_i, `RPSM_ADDR_PORT_SEL) |=> reg_rdata_o[7:PW] == '0)
        else $error("Unused port select bits read as one.");
    a_sel_kept: assert property (
        !(reg_wr_i && hit(reg_addr_i, `RPSM_ADDR_PORT_SEL)) |=> $stable(sel_q))
        else $error("Port select moved without a write to it.");
    a_other_port_kept: assert property (
        rd_status && sel_q != '0 && flags_q[0][`RPSM_BIT_BUF_ERR]
        |=> flags_q[0][`RPSM_BIT_BUF_ERR])
        else $error("Reading another port cleared port zero.");
    a_shadow_kept: assert property (
        !rd_int |=> $stable(frac_shadow_q))
        else $error("Fraction shadow moved without an integer read.");
    a_frac_read: assert property (
        reg_rd_i && hit(reg_addr_i, `RPSM_ADDR_FREQ_FRAC) |=> reg_rdata_o == $past(frac_shadow_q))
        else $error("Fraction byte not taken from the shadow.");
    a_settled_shown: assert property (
        rd_status |=> reg_rdata_o[`RPSM_BIT_FREQ_SETTLED] == $past(settled[sel_q]))
        else $error("Frequency settled bit wrong.");
    a_lenchg_shown: assert property (
        rd_status |=> reg_rdata_o[`RPSM_BIT_LEN_CHANGED]
        == $past(flags_q[sel_q][`RPSM_BIT_LEN_CHANGED]))
        else $error("Line length flag not returned on read.");
    a_coding_shown: assert property (
        rd_status |=> reg_rdata_o[`RPSM_BIT_CODING_ERR]
        == $past(flags_q[sel_q][`RPSM_BIT_CODING_ERR]))
        else $error("Coding error flag not returned on read.");

    // Events reach the flags of port zero one cycle after they are seen.
    a_unstable_set: assert property (
        line_ev[0].len_unstable |=> flags_q[0][`RPSM_BIT_LEN_UNSTABLE])
        else $error("Instability event lost.");
    a_lenchg_set: assert property (
        line_ev[0].len_changed |=> flags_q[0][`RPSM_BIT_LEN_CHANGED])
        else $error("Line length change event lost.");
    a_cntchg_set: assert property (
        line_ev[0].cnt_changed |=> flags_q[0][`RPSM_BIT_CNT_CHANGED])
        else $error("Line count change event lost.");
    a_buffer_set: assert property (
        port_in_i[0].buf_overflow |=> flags_q[0][`RPSM_BIT_BUF_ERR])
        else $error("Buffer overflow lost.");

    // Sticky bits hold until the selected port's status is read.
    a_lenchg_kept: assert property (
        flags_q[0][`RPSM_BIT_LEN_CHANGED] && !(rd_status && sel_q == '0)
        |=> flags_q[0][`RPSM_BIT_LEN_CHANGED])
        else $error("Line length flag dropped without a read.");
    a_coding_kept: assert property (
        flags_q[0][`RPSM_BIT_CODING_ERR] && !(rd_status && sel_q == '0)
        |=> flags_q[0][`RPSM_BIT_CODING_ERR])
        else $error("Coding error flag dropped without a read.");
    a_buffer_kept: assert property (
        flags_q[0][`RPSM_BIT_BUF_ERR] && !(rd_status && sel_q == '0)
        |=> flags_q[0][`RPSM_BIT_BUF_ERR])
        else $error("Buffer flag dropped without a read.");
    a_cntchg_kept: assert property (
        flags_q[0][`RPSM_BIT_CNT_CHANGED] && !(rd_status && sel_q == '0)
        |=> flags_q[0][`RPSM_BIT_CNT_CHANGED])
        else $error("Line count flag dropped without a read.");

    // A read with no new event in the same cycle leaves the bit clear.
    a_unstable_clear: assert property (
        rd_status && sel_q == '0 && !set_bits[0][`RPSM_BIT_LEN_UNSTABLE]
        |=> !flags_q[0][`RPSM_BIT_LEN_UNSTABLE])
        else $error("Instability flag not cleared by read.");
    a_coding_clear: assert property (
        rd_status && sel_q == '0 && !set_bits[0][`RPSM_BIT_CODING_ERR]
        |=> !flags_q[0][`RPSM_BIT_CODING_ERR])
        else $error("Coding error flag not cleared by read.");
    a_cntchg_clear: assert property (
        rd_status && sel_q == '0 && !set_bits[0][`RPSM_BIT_CNT_CHANGED]
        |=> !flags_q[0][`RPSM_BIT_CNT_CHANGED])
        else $error("Line count flag not cleared by read.");

    c_status_read_set: cover property (rd_status ##1 reg_rdata_o != `RPSM_RESET_BYTE);
    c_freq_pair_read: cover property (rd_int ##[1:4] (reg_rd_i &&
        hit(reg_addr_i, `RPSM_ADDR_FREQ_FRAC)));
    c_port_switch: cover property (sel_q != '0 && rd_status);
    c_set_during_read: cover property (rd_status && sel_q == '0 && port_in_i[0].coding_err);
    c_absent_read: cover property (rd_status ##1 reg_rdata_o[`RPSM_BIT_CLK_ABSENT]);
endmodule // rpsm_top

// ### test/rpsm_far_model.sv
// Far-side model of the serializers: frame timing, error pulses and link clocks per port.
`timescale 1ns/1ps
module rpsm_far_model
    import rpsm_pkg::*;
#(
    parameter int NP = 4
) (
    input wire logic core_clk_i,
    output rpsm_port_in_type port_o [NP],
    output logic [NP-1:0] link_clk_o
);
    int half_ns [NP];

    initial begin
        for (int i = 0; i < NP; i++) begin
            port_o[i] = '0;
        end
    end

    // A port without a running serializer keeps its link clock low rather than free running.
    for (genvar g = 0; g < NP; g++) begin : g_clk
        always begin
            if (half_ns[g] == 0) begin
                link_clk_o[g] = 1'b0;
                @(half_ns[g]);
            end else begin
                #(half_ns[g]) link_clk_o[g] = ~link_clk_o[g];
            end
        end
    end

    task automatic set_clk(input int p, input int half);
        half_ns[p] = half;
    endtask

    // Every pulse lasts one clock; each line is spaced by its length from the previous mark.
    task automatic frame(input int p, input int n, input int len, input int last_len);
        @(negedge core_clk_i) port_o[p].frame_start = 1'b1;
        @(negedge core_clk_i) port_o[p].frame_start = 1'b0;
        for (int i = 0; i < n; i++) begin
            repeat ((i == n - 1) ? last_len : len) @(negedge core_clk_i);
            port_o[p].line_end = 1'b1;
            @(negedge core_clk_i) port_o[p].line_end = 1'b0;
        end
    endtask

    // Coding errors are raised as single pulses while lock is held, as with a high threshold.
    task automatic pulse(input int p, input bit ovf);
        @(negedge core_clk_i);
        if (ovf) port_o[p].buf_overflow = 1'b1;
        else port_o[p].coding_err = 1'b1;
        @(negedge core_clk_i);
        port_o[p].buf_overflow = 1'b0;
        port_o[p].coding_err = 1'b0;
    endtask

    task automatic set_csi(input int p, input logic v);
        @(negedge core_clk_i);
        port_o[p].csi_error = v;
    endtask
endmodule // rpsm_far_model

// ### test/testbench.sv
// Self-checking bench for the port status flags and link frequency registers.
`timescale 1ns/1ps
module testbench;
    import rpsm_pkg::*;
    // A short gate keeps the run brief; a 4-cycle link period gives GATE/4 edges per gate.
    localparam int GATE = 2560;
    localparam logic [15:0] E0 = GATE / 4;
    localparam logic [15:0] E1 = GATE / 8;
    typedef struct {
        bit wr;
        logic [7:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
    } rpsm_row_type;
    logic core_clk;
    logic nrst;
    rpsm_port_in_type port_in [4];
    logic [3:0] link_clk;
    logic [3:0][7:0] thr;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] v;
    int fails = 0;
    int tests_run = 0;
    rpsm_row_type rows [12] = '{
        '{1'b0, 8'h4C, 8'h00, 8'h00}, '{1'b0, 8'h4E, 8'h00, 8'h00},
        '{1'b0, 8'h4F, 8'h00, 8'h00}, '{1'b0, 8'h50, 8'h00, 8'h00},
        '{1'b1, 8'h4C, 8'hFF, 8'h00}, '{1'b0, 8'h4C, 8'h00, 8'h03},
        '{1'b0, 8'h51, 8'h00, 8'h00}, '{1'b1, 8'h4E, 8'hFF, 8'h00},
        '{1'b0, 8'h4E, 8'h00, 8'h00}, '{1'b1, 8'h4F, 8'h55, 8'h00},
        '{1'b0, 8'h4F, 8'h00, 8'h00}, '{1'b1, 8'h4C, 8'h00, 8'h00}
    };

    rpsm_far_model #(.NP(4)) rpsm_far_model_i (
        .core_clk_i(core_clk),
        .port_o(port_in),
        .link_clk_o(link_clk)
    );

    rpsm_top #(.NUM_PORTS(4), .GATE_CYCLES(GATE)) rpsm_top_i (
        .core_clk_i(core_clk),
        .nrst_i(nrst),
        .port_in_i(port_in),
        .link_clk_i(link_clk),
        .low_freq_thresh_i(thr),
        .reg_addr_i(addr),
        .reg_wr_i(wr),
        .reg_rd_i(rd),
        .reg_wdata_i(wdata),
        .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // A read that brings no valid strobe yields unknown data, so it can never match.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        addr = a;
        rd = 1'b1;
        @(negedge core_clk);
        rd = 1'b0;
        d = (rvalid === 1'b1) ? rdata : 8'hXX;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge core_clk);
        wr = 1'b0;
    endtask

    // Line events land two cycles after the closing frame start; the clock bits are masked.
    task automatic sts(output logic [7:0] d);
        repeat (3) @(negedge core_clk);
        rd_reg(8'h4E, d);
        d = d & 8'hF9;
    endtask

    task automatic give_verdict();
        if (fails == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #500000;
        fails++;
        give_verdict();
    end

    initial begin
        addr = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
        thr = '0;
        nrst = 1'b0;
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr_reg(rows[i].addr, rows[i].data);
            end else begin
                rd_reg(rows[i].addr, v);
                check(v, rows[i].exp);
            end
        end
        rpsm_far_model_i.frame(0, 4, 10, 10);
        rpsm_far_model_i.frame(0, 4, 10, 10);
        rpsm_far_model_i.frame(0, 0, 0, 0);
        sts(v);
        check(v, 8'h00);
        rpsm_far_model_i.frame(0, 3, 12, 12);
        rpsm_far_model_i.frame(0, 0, 0, 0);
        sts(v);
        check(v, 8'h41);
        sts(v);
        check(v, 8'h00);
        rpsm_far_model_i.frame(0, 3, 12, 15);
        rpsm_far_model_i.frame(0, 0, 0, 0);
        sts(v);
        check(v, 8'hC0);
        sts(v);
        check(v, 8'h00);
        rpsm_far_model_i.pulse(1, 1'b0);
        rpsm_far_model_i.pulse(0, 1'b1);
        rpsm_far_model_i.pulse(0, 1'b0);
        wr_reg(8'h4C, 8'h01);
        sts(v);
        check(v, 8'h20);
        sts(v);
        check(v, 8'h00);
        wr_reg(8'h4C, 8'h00);
        sts(v);
        check(v, 8'h30);
        // An error arriving in the very cycle of the clearing read must survive it.
        fork
            rpsm_far_model_i.pulse(0, 1'b0);
            rd_reg(8'h4E, v);
        join
        check(v, 8'h00);
        sts(v);
        check(v, 8'h20);
        rpsm_far_model_i.set_csi(0, 1'b1);
        sts(v);
        check(v, 8'h08);
        sts(v);
        check(v, 8'h08);
        rpsm_far_model_i.set_csi(0, 1'b0);
        sts(v);
        check(v, 8'h00);
        thr[0] = 8'h02;
        thr[1] = 8'h02;
        rpsm_far_model_i.set_clk(0, 20);
        rpsm_far_model_i.set_clk(1, 40);
        repeat (4 * GATE) @(negedge core_clk);
        rd_reg(8'h4E, v);
        check(v, 8'h04);
        rd_reg(8'h4F, v);
        check(v, E0[15:8]);
        rd_reg(8'h50, v);
        check(v, E0[7:0]);
        wr_reg(8'h4C, 8'h01);
        rd_reg(8'h4E, v);
        check(v, 8'h02);
        rd_reg(8'h4F, v);
        check(v, E1[15:8]);
        rd_reg(8'h50, v);
        check(v, E1[7:0]);
        wr_reg(8'h4C, 8'h00);
        rpsm_far_model_i.set_clk(0, 0);
        repeat (2 * GATE + 20) @(negedge core_clk);
        rd_reg(8'h4E, v);
        check(v, 8'h02);
        rd_reg(8'h4F, v);
        check(v, 8'h00);
        wr_reg(8'h4C, 8'h01);
        rpsm_far_model_i.pulse(1, 1'b1);
        nrst = 1'b0;
        repeat (2) @(negedge core_clk);
        nrst = 1'b1;
        rd_reg(8'h4C, v);
        check(v, 8'h00);
        wr_reg(8'h4C, 8'h01);
        rd_reg(8'h4E, v);
        check(v, 8'h00);
        give_verdict();
    end
endmodule // testbench
